// file: design/bas_datapath.sv
// Byte add/subtract datapath with I/O mode control and register port
`timescale 1ns/100ps
`include "bas_defines.svh"

module bas_datapath (
   input  wire logic                   ref_clk_i,
   input  wire logic                   resetn_i,
   input  wire logic                   cmd_valid_i,
   input  wire bas_pkg::bas_cmd_t      cmd_i,
   input  wire logic [`BAS_DW-1:0]     in_bus_i,
   input  wire bas_pkg::bas_bus_req_t  bus_i,
   output logic [`BAS_DW-1:0]          rdata_o,
   output logic                        done_o,
   output logic                        cmd_err_o,
   output logic                        link_o,
   output bas_pkg::bas_flags_t         flags_o,
   output logic [`BAS_DW-1:0]          t_bus_o,
   output logic [`BAS_LW-1:0]          loc_o,
   output logic [2:0]                  io_ctrl_o,
   output logic                        in_bus_en_flag_o,
   output logic                        data_input_strobe_o,
   output logic                        tty_space_o,
   output logic                        int_ack_o
);
   import bas_pkg::*;

   bas_state_t               cur_ff;
   bas_state_t               nxt_st;
   logic                     exec;
   logic                     is_sub;
   logic                     link_ctl;
   logic [`BAS_DW-1:0]       t_src;
   logic [`BAS_DW-1:0]       fval;
   logic [`BAS_DW-1:0]       opnd;
   logic                     cin;
   logic [`BAS_DW:0]         sum9;
   logic [`BAS_DW-1:0]       res;
   bas_flags_t               new_flags;

   // Register readback decode
   function automatic logic [`BAS_DW-1:0] reg_read(input bas_state_t s,
                                                    input logic [`BAS_AW-1:0] a);
      logic [`BAS_DW-1:0] v;
      v = `BAS_RST_BYTE;
      if (a <= `BAS_A_FILE_TOP) begin
         v = s.files[a[3:0]];
      end else begin
         case (a)
            `BAS_A_T:      v = s.t;
            `BAS_A_N:      v = s.n;
            `BAS_A_M:      v = s.m;
            `BAS_A_LOC_LO: v = s.loc[7:0];
            `BAS_A_LOC_HI: v = {7'h00, s.loc[8]};
            `BAS_A_STATUS: v = {4'h0, s.flags, s.link};
            `BAS_A_IOCTL:  v = {5'h00, s.io_ctrl};
            default:       v = `BAS_RST_BYTE;
         endcase
      end
      return v;
   endfunction : reg_read

   // Add and subtract share file selection and the refusal check
   function automatic logic is_arith(input bas_op_t o);
      return (o == BAS_OP_ADD) || (o == BAS_OP_SUB);
   endfunction : is_arith

   // Mode decode shared by the three I/O mode outputs
   function automatic logic mode_is(input logic [2:0] m, input logic [2:0] code);
      return m == code;
   endfunction : mode_is

   // File 0 holds no operand; such a command is refused
   assign exec     = cmd_valid_i && is_arith(cmd_i.op)
                     && (cmd_i.f != 4'h0);
   assign is_sub   = (cmd_i.op == BAS_OP_SUB);
   assign link_ctl = cmd_i.c[`BAS_C_LINK];
   assign fval     = cur_ff.files[cmd_i.f];

   // Only the synchronised copy of the input bus is looked at
   assign t_src = cur_ff.io_ctrl[`BAS_IO_INEN] ? cur_ff.in_sync : cur_ff.t;

   always_comb begin
      if (!is_sub) begin
         opnd = cmd_i.c[`BAS_C_SELT] ? t_src : 8'h00;
         if (cmd_i.c[`BAS_C_ONE]) begin
            cin = 1'b1;
         end else begin
            cin = link_ctl & cur_ff.link;
         end
      end else begin
         // No complemented input bus path exists, so select-T uses T even when the input bus is enabled
         opnd = cmd_i.c[`BAS_C_SELT] ? ~cur_ff.t : 8'hff;
         if (link_ctl) begin
            cin = cur_ff.link;
         end else begin
            cin = ~cmd_i.c[`BAS_C_ONE];
         end
      end
   end

   assign sum9 = {1'b0, fval} + {1'b0, opnd} + {8'h00, cin};
   assign res  = sum9[`BAS_DW-1:0];

   always_comb begin
      new_flags.neg  = res[`BAS_DW-1];
      new_flags.ovf  = (fval[`BAS_DW-1] == opnd[`BAS_DW-1]) &&
                       (res[`BAS_DW-1] != fval[`BAS_DW-1]);
      new_flags.zero = (res == 8'h00);
      if (link_ctl) begin
         // Linked zero test across bytes: zero may only fall
         new_flags.zero = (res == 8'h00) && cur_ff.flags.zero;
      end
   end

   always_comb begin
      nxt_st         = cur_ff;
      nxt_st.in_meta = in_bus_i;
      nxt_st.in_sync = cur_ff.in_meta;
      nxt_st.done    = 1'b0;
      nxt_st.err     = 1'b0;
      nxt_st.rdata   = bus_i.rd ? reg_read(cur_ff, bus_i.addr) : `BAS_RST_BYTE;

      // Register port writes; a same-cycle command overrides them below
      if (bus_i.wr) begin
         if (bus_i.addr <= `BAS_A_FILE_TOP) begin
            nxt_st.files[bus_i.addr[3:0]] = bus_i.wdata;
         end else begin
            case (bus_i.addr)
               `BAS_A_T:      nxt_st.t = bus_i.wdata;
               `BAS_A_N:      nxt_st.n = bus_i.wdata;
               `BAS_A_M:      nxt_st.m = bus_i.wdata;
               `BAS_A_LOC_LO: nxt_st.loc[7:0] = bus_i.wdata;
               `BAS_A_LOC_HI: nxt_st.loc[8] = bus_i.wdata[0];
               `BAS_A_STATUS: begin
                  nxt_st.flags = bus_i.wdata[3:1];
                  nxt_st.link  = bus_i.wdata[0];
               end
               default: nxt_st.rdata = nxt_st.rdata;
            endcase
         end
      end

      if (cmd_valid_i) begin
         nxt_st.done = 1'b1;
         nxt_st.err  = !exec && is_arith(cmd_i.op);
         nxt_st.loc  = cur_ff.loc + 9'h001;
      end

      if (exec) begin
         if (!cmd_i.star) begin
            nxt_st.files[cmd_i.f] = res;
         end
         nxt_st.link = sum9[`BAS_DW];
         if (cmd_i.c[`BAS_C_FLAGS]) begin
            nxt_st.flags = new_flags;
         end
         case (cmd_i.dst)
            BAS_DST_T:   nxt_st.t = res;
            BAS_DST_N:   nxt_st.n = res;
            BAS_DST_M:   nxt_st.m = res;
            BAS_DST_LOC: nxt_st.loc = {cur_ff.loc[8], res};
            default:     nxt_st.t = nxt_st.t;
         endcase
      end

      // I/O mode programmed at the end of the control command
      if (cmd_valid_i && cmd_i.op == BAS_OP_CTL && cmd_i.c[`BAS_C_IOSET]) begin
         nxt_st.io_ctrl = cmd_i.c[2:0];
      end
      nxt_st.tty_space  = mode_is(nxt_st.io_ctrl, `BAS_IO_SPACE);
      nxt_st.int_ack    = mode_is(nxt_st.io_ctrl, `BAS_IO_ACK);
      nxt_st.din_strobe = mode_is(nxt_st.io_ctrl, `BAS_IO_DIN);
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_st;
      end
   end

   assign rdata_o             = cur_ff.rdata;
   assign done_o              = cur_ff.done;
   assign cmd_err_o           = cur_ff.err;
   assign link_o              = cur_ff.link;
   assign flags_o             = cur_ff.flags;
   assign t_bus_o             = cur_ff.t;
   assign loc_o               = cur_ff.loc;
   assign io_ctrl_o           = cur_ff.io_ctrl;
   assign in_bus_en_flag_o    = cur_ff.io_ctrl[`BAS_IO_INEN];
   assign data_input_strobe_o = cur_ff.din_strobe;
   assign tty_space_o         = cur_ff.tty_space;
   assign int_ack_o           = cur_ff.int_ack;

   // Checks
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);

   localparam int CMD_MAX = `BAS_CMD_CYCLES;

   a_add_file_wr: assert property (
      exec && !is_sub && !cmd_i.star |=> cur_ff.files[$past(cmd_i.f)] == $past(res))
      else $error("add result not written to file");

   a_link_carry: assert property (
      exec |=> link_o == $past(sum9[8]))
      else $error("link does not hold adder carry");

   a_zero_linked: assert property (
      exec && link_ctl && cmd_i.c[0] && !flags_o.zero |=> !flags_o.zero)
      else $error("linked zero flag was set");

   a_or_one: assert property (
      exec && !is_sub && cmd_i.c[3] && cmd_i.c[2] |-> cin && sum9 == {1'b0, fval} + {1'b0, opnd} + 9'h001)
      else $error("link and add-one not ORed");

   a_done_period: assert property (
      cmd_valid_i |-> ##[1:CMD_MAX] done_o)
      else $error("command did not complete in its period");

   a_sub_oper: assert property (
      exec && is_sub && !cmd_i.c[1] |-> opnd == 8'hff)
      else $error("subtract operand not all ones");

   a_sub_diff: assert property (
      exec && is_sub && cmd_i.c == 4'h2 && cmd_i.dst == BAS_DST_N
      |=> cur_ff.n == $past(fval) - $past(cur_ff.t))
      else $error("subtract difference wrong");

   a_flags_hold: assert property (
      exec && !cmd_i.c[0] && !bus_i.wr |=> $stable(flags_o))
      else $error("flags changed without modify bit");

   a_io_mode: assert property (
      cmd_valid_i && cmd_i.op == BAS_OP_CTL && cmd_i.c == 4'hb
      |=> io_ctrl_o == 3'h3 && tty_space_o)
      else $error("space mode not taken");

   a_ack_mode: assert property (
      cmd_valid_i && cmd_i.op == BAS_OP_CTL && cmd_i.c == 4'hd |=> int_ack_o && io_ctrl_o == 3'h5)
      else $error("acknowledge mode not taken");

   a_loc_step: assert property (
      cmd_valid_i && !(exec && cmd_i.dst == BAS_DST_LOC) && !bus_i.wr
      |=> loc_o == $past(loc_o) + 9'h001)
      else $error("location counter did not advance");

   a_in_sel: assert property (
      exec && !is_sub && cmd_i.c[1] && in_bus_en_flag_o |-> opnd == cur_ff.in_sync)
      else $error("input bus not selected for T");

   // Refused commands leave the files, T, N, M, link and flags alone; the location counter still advances
   a_refused_cmd: assert property (
      cmd_valid_i && is_arith(cmd_i.op) && cmd_i.f == 4'h0 && !bus_i.wr
      |=> cmd_err_o && $stable(link_o) && $stable(flags_o) && $stable(t_bus_o))
      else $error("refused command changed state");

   a_add_one: assert property (
      exec && !is_sub && cmd_i.c == 4'h4 |-> sum9 == {1'b0, fval} + 9'h001)
      else $error("add-one not added");

   a_add_pass: assert property (
      exec && !is_sub && !cmd_i.c[`BAS_C_SELT] |-> opnd == 8'h00)
      else $error("add operand not zero without select-T");

   a_sub_link: assert property (
      exec && is_sub && link_ctl |-> cin == cur_ff.link)
      else $error("subtract carry-in is not the link");

   a_sub_inhibit: assert property (
      exec && is_sub && !link_ctl && cmd_i.c[`BAS_C_ONE] |-> !cin)
      else $error("subtract increment not inhibited");

   a_sub_cmpl: assert property (
      exec && is_sub && cmd_i.c[`BAS_C_SELT] |-> opnd == ~cur_ff.t)
      else $error("subtract operand not complemented T");

   a_space_line: assert property (
      cmd_valid_i && cmd_i.op == BAS_OP_CTL && cmd_i.c == 4'hb
      |=> tty_space_o && !int_ack_o && !data_input_strobe_o)
      else $error("teletype line not held at space");

   a_neg_flag: assert property (
      exec && cmd_i.c[`BAS_C_FLAGS] |=> flags_o.neg == $past(res[`BAS_DW-1]))
      else $error("negative flag not result bit 7");

   // Operands of unlike sign can never overflow
   a_ovf_flag: assert property (
      exec && cmd_i.c[`BAS_C_FLAGS] && fval[`BAS_DW-1] != opnd[`BAS_DW-1] |=> !flags_o.ovf)
      else $error("overflow set for unlike signs");

   a_plain_link: assert property (
      exec && !cmd_i.c[`BAS_C_FLAGS] && !bus_i.wr
      |=> link_o == $past(sum9[`BAS_DW]) && $stable(flags_o))
      else $error("link or flags wrong without modify bit");

   a_loc_load: assert property (
      exec && cmd_i.dst == BAS_DST_LOC
      |=> loc_o[`BAS_DW-1:0] == $past(res) && loc_o[`BAS_DW] == $past(loc_o[`BAS_DW]))
      else $error("location counter not loaded from result");

   a_done_pulse: assert property (
      !cmd_valid_i |=> !done_o)
      else $error("done without a command");

   a_star_keep: assert property (
      exec && cmd_i.star && !bus_i.wr
      |=> cur_ff.files[$past(cmd_i.f)] == $past(fval))
      else $error("file written although star set");

   a_dest_n: assert property (
      exec && cmd_i.dst == BAS_DST_N |=> cur_ff.n == $past(res))
      else $error("add result not in destination");

   c_add_link: cover property (exec && !is_sub && link_ctl);
   c_refused: cover property (cmd_err_o);
   c_input_add: cover property (exec && !is_sub && in_bus_en_flag_o);
   c_sub_ones: cover property (exec && is_sub && cmd_i.c[2]);
   c_din_mode: cover property (data_input_strobe_o ##1 cmd_valid_i);
endmodule : bas_datapath

// file: design/bas_defines.svh
// Constants for the byte add/subtract datapath
`ifndef BAS_DEFINES_SVH
`define BAS_DEFINES_SVH

// Widths
`define BAS_DW          8
`define BAS_AW          5
`define BAS_LW          9
`define BAS_NFILE       16

// Command timing
`define BAS_CLK_PERIOD_NS   4
`define BAS_CMD_PERIOD_NS   220
`define BAS_CMD_CYCLES      (`BAS_CMD_PERIOD_NS / `BAS_CLK_PERIOD_NS)

// c field bits of add and subtract
`define BAS_C_LINK      3
`define BAS_C_ONE       2
`define BAS_C_SELT      1
`define BAS_C_FLAGS     0
// c field bit that marks a set-I/O-mode control command
`define BAS_C_IOSET     3

// I/O modes
`define BAS_IO_SPACE    3'h3
`define BAS_IO_ACK      3'h5
`define BAS_IO_DIN      3'h6
`define BAS_IO_INEN     2

// Register bus offsets (files sit at 5'h00 to 5'h0f)
`define BAS_A_FILE_TOP  5'h0f
`define BAS_A_T         5'h10
`define BAS_A_N         5'h11
`define BAS_A_M         5'h12
`define BAS_A_LOC_LO    5'h13
`define BAS_A_LOC_HI    5'h14
`define BAS_A_STATUS    5'h15
`define BAS_A_IOCTL     5'h16

// Reset values
`define BAS_RST_BYTE    8'h00
`define BAS_RST_LOC     9'h000
`define BAS_RST_IO      3'h0

`endif

// file: design/bas_pkg.sv
// Types shared by the byte add/subtract datapath
`include "bas_defines.svh"
package bas_pkg;
   typedef enum logic [1:0] {
      BAS_OP_NOP = 2'b00,
      BAS_OP_ADD = 2'b01,
      BAS_OP_SUB = 2'b10,
      BAS_OP_CTL = 2'b11
   } bas_op_t;

   typedef enum logic [2:0] {
      BAS_DST_NONE = 3'b000,
      BAS_DST_T    = 3'b001,
      BAS_DST_N    = 3'b010,
      BAS_DST_M    = 3'b011,
      BAS_DST_LOC  = 3'b100
   } bas_dst_t;

   typedef struct packed {
      bas_op_t    op;
      logic [3:0] f;
      logic       star;
      bas_dst_t   dst;
      logic [3:0] c;
   } bas_cmd_t;

   typedef struct packed {
      logic ovf;
      logic neg;
      logic zero;
   } bas_flags_t;

   typedef struct packed {
      logic                    wr;
      logic                    rd;
      logic [`BAS_AW-1:0]      addr;
      logic [`BAS_DW-1:0]      wdata;
   } bas_bus_req_t;

   typedef struct packed {
      logic [`BAS_NFILE-1:0][`BAS_DW-1:0] files;
      logic [`BAS_DW-1:0]      t;
      logic [`BAS_DW-1:0]      n;
      logic [`BAS_DW-1:0]      m;
      logic [`BAS_LW-1:0]      loc;
      logic                    link;
      bas_flags_t              flags;
      logic [2:0]              io_ctrl;
      logic                    tty_space;
      logic                    int_ack;
      logic                    din_strobe;
      logic [`BAS_DW-1:0]      in_meta;
      logic [`BAS_DW-1:0]      in_sync;
      logic [`BAS_DW-1:0]      rdata;
      logic                    done;
      logic                    err;
   } bas_state_t;
endpackage : bas_pkg

// file: test/bas_datapath_tb_top.sv
// Self-checking testbench for the byte add/subtract datapath
`timescale 1ns/100ps
`include "bas_defines.svh"
module bas_datapath_tb_top;
   import bas_pkg::*;
   localparam int LIMIT = 3000;
   logic         ref_clk_i;
   logic         resetn_i;
   logic         cmd_valid_i;
   bas_cmd_t     cmd_i;
   logic [7:0]   in_bus_i;
   bas_bus_req_t bus_i;
   logic [7:0]   rdata_o, t_bus_o;
   logic         done_o, cmd_err_o, link_o, in_bus_en_flag_o;
   logic         data_input_strobe_o, tty_space_o, int_ack_o;
   bas_flags_t   flags_o, mfl;
   logic [8:0]   loc_o, mloc;
   logic [2:0]   io_ctrl_o, mio;
   int           errors = 0;
   int           cmp_count = 0;
   int           cycles = 0;
   int           k;
   bas_op_t      op;
   logic         rd_q, mlink, merr;
   logic [28:0]  cq[$];
   logic [7:0]   rq[$];
   logic [7:0]   mf[16];
   logic [7:0]   mt, mn, mm;
   wire logic [28:0] seen_vec = {cmd_err_o, link_o, flags_o, t_bus_o, loc_o, io_ctrl_o,
                                 tty_space_o, int_ack_o, data_input_strobe_o, in_bus_en_flag_o};

   bas_datapath uut (.ref_clk_i, .resetn_i, .cmd_valid_i, .cmd_i, .in_bus_i, .bus_i, .rdata_o, .done_o,
      .cmd_err_o, .link_o, .flags_o, .t_bus_o, .loc_o, .io_ctrl_o, .in_bus_en_flag_o, .data_input_strobe_o,
      .tty_space_o, .int_ack_o);

   initial begin
      ref_clk_i = 1'b0;
      forever #2 ref_clk_i = ~ref_clk_i;
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic report_and_stop();
      if (errors == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : report_and_stop

   function automatic logic [7:0] rd_model(input logic [4:0] a);
      case (a)
         `BAS_A_T:      return mt;
         `BAS_A_N:      return mn;
         `BAS_A_M:      return mm;
         `BAS_A_LOC_LO: return mloc[7:0];
         `BAS_A_LOC_HI: return {7'h00, mloc[8]};
         `BAS_A_STATUS: return {4'h0, mfl, mlink};
         `BAS_A_IOCTL:  return {5'h00, mio};
         default:       return (a <= `BAS_A_FILE_TOP) ? mf[a[3:0]] : 8'h00;
      endcase
   endfunction : rd_model

   task automatic idle(input int n);
      repeat (n) begin
         @(posedge ref_clk_i);
         cmd_valid_i <= 1'b0;
         bus_i       <= '0;
      end
   endtask : idle

   task automatic do_reset();
      @(posedge ref_clk_i);
      resetn_i    <= 1'b0;
      cmd_valid_i <= 1'b0;
      bus_i       <= '0;
      repeat (2) @(posedge ref_clk_i);
      resetn_i <= 1'b1;
      foreach (mf[i]) mf[i] = 8'h00;
      {mt, mn, mm, mloc, mlink, mfl, mio, merr} = '0;
   endtask : do_reset

   task automatic bus_op(input logic wr, input logic [4:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      cmd_valid_i <= 1'b0;
      bus_i       <= '{wr: wr, rd: !wr, addr: a, wdata: d};
      if (!wr) begin
         rq.push_back(rd_model(a));
      end else begin
         case (a)
            `BAS_A_T: mt = d;
            `BAS_A_N: mn = d;
            `BAS_A_M: mm = d;
            default:  if (a <= `BAS_A_FILE_TOP) mf[a[3:0]] = d;
         endcase
      end
   endtask : bus_op

   task automatic do_cmd(input bas_op_t o, input logic [3:0] f, input logic star, input bas_dst_t dst,
                         input logic [3:0] c);
      logic [7:0] a, b, r;
      logic [8:0] s;
      logic       ci, arith;
      @(posedge ref_clk_i);
      cmd_valid_i <= 1'b1;
      bus_i       <= '0;
      cmd_i       <= '{op: o, f: f, star: star, dst: dst, c: c};
      arith = (o == BAS_OP_ADD || o == BAS_OP_SUB);
      merr  = arith && f == 4'h0;
      r     = 8'h00;
      if (arith && !merr) begin
         a = mf[f];
         if (o == BAS_OP_ADD) begin
            b  = c[1] ? (mio[`BAS_IO_INEN] ? in_bus_i : mt) : 8'h00;
            ci = c[2] | (c[3] & mlink);
         end else begin
            b  = c[1] ? ~mt : 8'hff;
            ci = c[3] ? mlink : ~c[2];
         end
         s = {1'b0, a} + {1'b0, b} + 9'(ci);
         r = s[7:0];
         if (c[0]) begin
            mfl = '{ovf: a[7] == b[7] && r[7] != a[7], neg: r[7], zero: r == 8'h00 && (!c[3] || mfl.zero)};
         end
         mlink = s[8];
         if (!star) mf[f] = r;
         case (dst)
            BAS_DST_T: mt = r;
            BAS_DST_N: mn = r;
            BAS_DST_M: mm = r;
            default:   ;
         endcase
      end else if (o == BAS_OP_CTL && c[`BAS_C_IOSET]) begin
         mio = c[2:0];
      end
      mloc = (arith && !merr && dst == BAS_DST_LOC) ? {mloc[8], r} : mloc + 9'h001;
      cq.push_back({merr, mlink, mfl, mt, mloc, mio, mio == `BAS_IO_SPACE, mio == `BAS_IO_ACK,
                    mio == `BAS_IO_DIN, mio[`BAS_IO_INEN]});
   endtask : do_cmd

   // Results are judged on the falling edge, when every register output has settled
   always @(posedge ref_clk_i) begin
      rd_q   <= resetn_i & bus_i.rd;
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         errors++;
         report_and_stop();
      end
   end

   always @(negedge ref_clk_i) begin
      if (resetn_i) begin
         if (rd_q) check("rdata", rdata_o, rq.pop_front());
         else check("rdata_idle", rdata_o, 32'h0);
         if (done_o !== 1'b0) begin
            if (cq.size() == 0) check("done_extra", done_o, 32'h0);
            else check("cmd_result", seen_vec, cq.pop_front());
         end
      end
   end

   initial begin
      resetn_i    = 1'b0;
      cmd_valid_i = 1'b0;
      cmd_i       = '0;
      bus_i       = '0;
      in_bus_i    = 8'h3c;
      void'($urandom(32'h64c1be70));
      do_reset();
      for (int a = 0; a < 32; a++) bus_op(1'b0, 5'(a), 8'h00);
      // Read-only and unmapped places ignore writes
      bus_op(1'b1, `BAS_A_IOCTL, 8'h5a);
      bus_op(1'b1, 5'h1f, 8'ha5);
      bus_op(1'b0, `BAS_A_IOCTL, 8'h00);
      bus_op(1'b0, 5'h1f, 8'h00);
      bus_op(1'b1, 5'h01, 8'h65);
      bus_op(1'b1, `BAS_A_T, 8'h9b);
      do_cmd(BAS_OP_ADD, 4'h1, 1'b0, BAS_DST_T, 4'h3);
      do_cmd(BAS_OP_ADD, 4'h0, 1'b0, BAS_DST_T, 4'h3);
      do_cmd(BAS_OP_SUB, 4'h0, 1'b0, BAS_DST_N, 4'hb);
      bus_op(1'b0, 5'h00, 8'h00);
      bus_op(1'b0, `BAS_A_STATUS, 8'h00);
      for (int c = 0; c < 16; c++) begin
         bus_op(1'b1, 5'h01, 8'($urandom));
         bus_op(1'b1, `BAS_A_T, 8'($urandom));
         do_cmd(BAS_OP_ADD, 4'h1, c[0], BAS_DST_N, 4'(c));
         do_cmd(BAS_OP_SUB, 4'h2, c[1], BAS_DST_M, 4'(c));
         do_cmd(BAS_OP_ADD, 4'h2, 1'b0, BAS_DST_T, 4'(c));
      end
      // Linked zero: may clear but never set again
      for (int a = 1; a < 4; a++) bus_op(1'b1, 5'(a), (a == 3) ? 8'h01 : 8'h00);
      bus_op(1'b1, `BAS_A_T, 8'h00);
      do_cmd(BAS_OP_ADD, 4'h1, 1'b0, BAS_DST_NONE, 4'h1);
      do_cmd(BAS_OP_ADD, 4'h2, 1'b0, BAS_DST_NONE, 4'h9);
      do_cmd(BAS_OP_ADD, 4'h3, 1'b0, BAS_DST_NONE, 4'h9);
      do_cmd(BAS_OP_ADD, 4'h2, 1'b0, BAS_DST_NONE, 4'h9);
      do_cmd(BAS_OP_ADD, 4'h3, 1'b1, BAS_DST_LOC, 4'h0);
      bus_op(1'b0, `BAS_A_LOC_LO, 8'h00);
      bus_op(1'b0, `BAS_A_LOC_HI, 8'h00);
      for (int c = 8; c < 16; c++) do_cmd(BAS_OP_CTL, 4'h1, 1'b1, BAS_DST_NONE, 4'(c));
      do_cmd(BAS_OP_CTL, 4'h1, 1'b1, BAS_DST_NONE, 4'h3);
      idle(1);
      in_bus_i <= 8'($urandom);
      idle(3);
      do_cmd(BAS_OP_CTL, 4'h1, 1'b1, BAS_DST_NONE, 4'he);
      // One spare clock before taking input data
      idle(1);
      do_cmd(BAS_OP_ADD, 4'h4, 1'b0, BAS_DST_T, 4'h3);
      // Single data byte to a three-latch interface: no control byte first
      bus_op(1'b1, `BAS_A_T, 8'h02);
      do_cmd(BAS_OP_CTL, 4'h1, 1'b1, BAS_DST_NONE, 4'ha);
      do_cmd(BAS_OP_CTL, 4'h1, 1'b1, BAS_DST_NONE, 4'h8);
      // Random traffic keeps the input bus disabled, so add with select-T reads T
      for (int i = 0; i < 400; i++) begin
         k  = $urandom_range(0, 5);
         op = bas_op_t'($urandom_range(0, 3));
         if (k == 0) bus_op(1'b1, 5'($urandom_range(0, 18)), 8'($urandom));
         else if (k == 1) bus_op(1'b0, 5'($urandom), 8'h00);
         else if (op == BAS_OP_CTL) do_cmd(op, 4'($urandom), 1'b1, BAS_DST_NONE, {2'b10, 2'($urandom)});
         else if (op == BAS_OP_NOP) do_cmd(op, 4'h0, 1'b1, BAS_DST_NONE, 4'h0);
         else do_cmd(op, 4'($urandom), 1'($urandom), bas_dst_t'($urandom_range(0, 7)), 4'($urandom));
      end
      idle(2);
      do_reset();
      bus_op(1'b0, 5'h01, 8'h00);
      bus_op(1'b0, `BAS_A_STATUS, 8'h00);
      idle(3);
      check("queues_left", cq.size() + rq.size(), 32'h0);
      report_and_stop();
   end
endmodule : bas_datapath_tb_top
